// file: design/hs_switch_pkg.sv
// Constants, register map and types of the high-side switch controller.
// Assumes a single 10 MHz system clock and an Avalon-MM register bus.
//
// Contract
// - Each output driven by software, timer or PWM.
// - Configuration writable only in Normal mode.
// - Restart or Fail-Safe forces all outputs off.
// - Supply over-voltage switches outputs off, unless disabled.
// - Supply under-voltage switches outputs off, unless disabled.
// - Without recovery, supply fault clears output configuration.
// - Supply faults set only their own flags.
// - Over-current longer than 16 us switches output off.
// - Over-current sets flag, resets configuration to 000.
// - Open-load for 64 us sets flag, output stays.
// - Open-load flags stay until software clears them.
// - Protection stays active in Stop and Sleep.
// - Two PWM generators with 8-bit duty.
// - Each generator runs at 200 Hz or 400 Hz.
// - PWM starts as soon as output is assigned.
// - Outputs assignable to timers or PWM, sharing allowed.
// - Tiny duty values may give no visible pulse.

package hs_switch_pkg;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_NS = 100;
   localparam int OC_FILTER_NS = 16000;
   localparam int OL_FILTER_NS = 64000;
   localparam int OC_CYCLES = (OC_FILTER_NS + CLK_NS - 1) / CLK_NS;
   localparam int OL_CYCLES = (OL_FILTER_NS + CLK_NS - 1) / CLK_NS;
   localparam int PWM_STEPS = 256;
   localparam int PWM_PERIOD_LO_NS = 5000000;
   localparam int PWM_PERIOD_HI_NS = 2500000;
   localparam int PWM_STEP_LO = PWM_PERIOD_LO_NS / (PWM_STEPS * CLK_NS);
   localparam int PWM_STEP_HI = PWM_PERIOD_HI_NS / (PWM_STEPS * CLK_NS);

   // ----------------------------------------------------------------
   // Register map (byte addresses) and fields
   // ----------------------------------------------------------------
   localparam int ADDR_W = 6;
   localparam logic [5:0] REG_CFG_A = 6'h00;
   localparam logic [5:0] REG_CFG_B = 6'h04;
   localparam logic [5:0] REG_DUTY1 = 6'h08;
   localparam logic [5:0] REG_DUTY2 = 6'h0c;
   localparam logic [5:0] REG_FREQ = 6'h10;
   localparam logic [5:0] REG_SUP_CTRL = 6'h14;
   localparam logic [5:0] REG_OC_STAT = 6'h18;
   localparam logic [5:0] REG_OL_STAT = 6'h1c;
   localparam logic [5:0] REG_SUP_STAT = 6'h20;
   localparam int CFG_LO_LSB = 0;
   localparam int CFG_HI_LSB = 4;
   localparam int OV_DIS_BIT = 0;
   localparam int UV_DIS_BIT = 1;
   localparam int REC_BIT = 2;
   localparam int OV_FLAG_BIT = 0;
   localparam int UV_FLAG_BIT = 1;
   localparam int OUT_STAT_LSB = 4;

   // ----------------------------------------------------------------
   // Output sources and chip modes
   // ----------------------------------------------------------------
   localparam logic [2:0] CFG_OFF = 3'h0;
   localparam logic [2:0] CFG_ON = 3'h1;
   localparam logic [2:0] CFG_TMR1 = 3'h2;
   localparam logic [2:0] CFG_TMR2 = 3'h3;
   localparam logic [2:0] CFG_PWM1 = 3'h4;
   localparam logic [2:0] CFG_PWM2 = 3'h5;

   typedef enum logic [2:0] {
      MODE_NORMAL = 3'b000,
      MODE_STOP = 3'b001,
      MODE_SLEEP = 3'b010,
      MODE_RESTART = 3'b011,
      MODE_FAILSAFE = 3'b100
   } mode_t;

endpackage

// file: design/fault_filter.sv
// Filter that reports a condition held for a given number of cycles.
// Assumes the condition input is already synchronous to i_clk_sys.
`timescale 1ns/1ps
module fault_filter #(
   parameter int CYCLES = 160
) (
   // Clock and reset
   input wire logic i_clk_sys,
   input wire logic i_resetn,
   // Condition and result
   input wire logic i_cond,
   output logic o_hit
);
   localparam int W = $clog2(CYCLES + 1);

   typedef struct packed {
      logic [W-1:0] cnt;
   } filt_t;

   filt_t s_ff;
   filt_t nxt_s;

   // The count holds at its limit so the hit repeats while the condition lasts.
   assign o_hit = i_cond && (s_ff.cnt == W'(CYCLES - 1));

   always_comb begin
      nxt_s = s_ff;
      if (!i_cond) begin
         nxt_s.cnt = '0;
      end else if (!o_hit) begin
         nxt_s.cnt = s_ff.cnt + W'(1);
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
         s_ff <= '0;
      end else begin
         s_ff <= nxt_s;
      end
   end
endmodule

// file: design/pwm_gen.sv
// Free-running 8-bit PWM generator with two selectable frequencies.
// Assumes duty and frequency inputs come from registers on i_clk_sys.
`timescale 1ns/1ps
module pwm_gen #(
   parameter int STEP_LO = 195,
   parameter int STEP_HI = 97
) (
   // Clock and reset
   input wire logic i_clk_sys,
   input wire logic i_resetn,
   // Settings
   input wire logic i_freq_hi,
   input wire logic [7:0] i_duty,
   // PWM level
   output logic o_on
);
   typedef struct packed {
      logic [7:0] pre;
      logic [7:0] phase;
      logic on;
   } pwm_t;

   pwm_t s_ff;
   pwm_t nxt_s;
   logic [7:0] lim;

   assign o_on = s_ff.on;

   always_comb begin
      nxt_s = s_ff;
      lim = i_freq_hi ? 8'(STEP_HI - 1) : 8'(STEP_LO - 1);
      // A compare with >= keeps the prescaler sane after a frequency change.
      if (s_ff.pre >= lim) begin
         nxt_s.pre = 8'h00;
         nxt_s.phase = s_ff.phase + 8'h01;
      end else begin
         nxt_s.pre = s_ff.pre + 8'h01;
      end
      // No minimum width is enforced; the switch itself swallows tiny pulses.
      nxt_s.on = s_ff.phase < i_duty;
   end

   always_ff @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
         s_ff <= '0;
      end else begin
         s_ff <= nxt_s;
      end
   end

   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (!i_resetn);

   property p_zero_off;
      (i_duty == 8'h00) [*2] |=> !o_on;
   endproperty
   a_zero_off: assert property (p_zero_off)
      else $error("PWM output on with zero duty.");
endmodule

// file: design/hs_switch_ctrl.sv
// Top of the high-side switch controller: registers, source selection,
// supply and load protection for four outputs.
// Assumes analog comparator outputs arrive asynchronously, while mode and
// timer levels come from logic on i_clk_sys.
//
// Implementation choices: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/1ps
module hs_switch_ctrl #(
   parameter int N_OUT = 4
) (
   // Clock and reset
   input wire logic i_clk_sys,
   input wire logic i_resetn,
   // Avalon-MM slave
   input wire logic [hs_switch_pkg::ADDR_W-1:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   input wire logic [3:0] i_avs_byteenable,
   output logic [31:0] o_avs_readdata,
   output logic o_avs_waitrequest,
   // Chip mode and timers
   input wire hs_switch_pkg::mode_t i_mode,
   input wire logic i_timer1,
   input wire logic i_timer2,
   // Analog comparators
   input wire logic i_supply_ov,
   input wire logic i_supply_uv,
   input wire logic [N_OUT-1:0] i_overcurrent,
   input wire logic [N_OUT-1:0] i_undercurrent,
   // Switch drive
   output logic [N_OUT-1:0] o_switch_output
);
   import hs_switch_pkg::*;

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [N_OUT-1:0][2:0] cfg;
      logic [7:0] duty1;
      logic [7:0] duty2;
      logic [1:0] freq;
      logic ov_dis;
      logic uv_dis;
      logic rec;
      logic [N_OUT-1:0] oc_flag;
      logic [N_OUT-1:0] ol_flag;
      logic ov_flag;
      logic uv_flag;
      logic [N_OUT-1:0] out;
      logic waitreq;
      logic [31:0] rdata;
      logic ov_m;
      logic ov_s;
      logic uv_m;
      logic uv_s;
      logic [N_OUT-1:0] oc_m;
      logic [N_OUT-1:0] oc_s;
      logic [N_OUT-1:0] ol_m;
      logic [N_OUT-1:0] ol_s;
      logic was_fail;
   } state_t;

   state_t s_ff;
   state_t nxt_s;

   function automatic logic [N_OUT-1:0] sticky(
      input logic [N_OUT-1:0] flag,
      input logic [N_OUT-1:0] clr,
      input logic [N_OUT-1:0] set
   );
      // A hardware set in the clearing cycle wins.
      return (flag & ~clr) | set;
   endfunction

   function automatic logic src_level(
      input logic [2:0] cfg,
      input logic t1,
      input logic t2,
      input logic p1,
      input logic p2
   );
      logic lvl;
      lvl = 1'b0;
      case (cfg)
         CFG_ON: lvl = 1'b1;
         CFG_TMR1: lvl = t1;
         CFG_TMR2: lvl = t2;
         CFG_PWM1: lvl = p1;
         CFG_PWM2: lvl = p2;
         default: lvl = 1'b0;
      endcase
      return lvl;
   endfunction

   // ----------------------------------------------------------------
   // PWM generators and fault filters
   // ----------------------------------------------------------------
   logic pwm1_on;
   logic pwm2_on;
   logic [N_OUT-1:0] oc_hit;
   logic [N_OUT-1:0] ol_hit;

   pwm_gen #(
      .STEP_LO(PWM_STEP_LO),
      .STEP_HI(PWM_STEP_HI)
   ) u_pwm1 (
      .i_clk_sys(i_clk_sys),
      .i_resetn(i_resetn),
      .i_freq_hi(s_ff.freq[0]),
      .i_duty(s_ff.duty1),
      .o_on(pwm1_on)
   );

   pwm_gen #(
      .STEP_LO(PWM_STEP_LO),
      .STEP_HI(PWM_STEP_HI)
   ) u_pwm2 (
      .i_clk_sys(i_clk_sys),
      .i_resetn(i_resetn),
      .i_freq_hi(s_ff.freq[1]),
      .i_duty(s_ff.duty2),
      .o_on(pwm2_on)
   );

   // Filters see only the driven state, so protection works in any mode.
   for (genvar g = 0; g < N_OUT; g++) begin : g_filt
      fault_filter #(
         .CYCLES(OC_CYCLES)
      ) u_oc (
         .i_clk_sys(i_clk_sys),
         .i_resetn(i_resetn),
         .i_cond(s_ff.out[g] && s_ff.oc_s[g]),
         .o_hit(oc_hit[g])
      );
      fault_filter #(
         .CYCLES(OL_CYCLES)
      ) u_ol (
         .i_clk_sys(i_clk_sys),
         .i_resetn(i_resetn),
         .i_cond(s_ff.out[g] && s_ff.ol_s[g]),
         .o_hit(ol_hit[g])
      );
   end

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   logic req;
   logic acc;
   logic wr;
   logic normal;
   logic fail;
   logic ov_act;
   logic uv_act;
   logic [7:0] wd;
   logic [N_OUT-1:0] clr_oc;
   logic [N_OUT-1:0] clr_ol;
   logic [31:0] rd;

   always_comb begin
      nxt_s = s_ff;
      req = i_avs_read || i_avs_write;
      // A request is answered one cycle after it is seen.
      acc = req && !s_ff.waitreq;
      nxt_s.waitreq = !(req && s_ff.waitreq);
      wr = acc && i_avs_write && i_avs_byteenable[0];
      wd = i_avs_writedata[7:0];
      normal = (i_mode == MODE_NORMAL);
      fail = (i_mode == MODE_RESTART) || (i_mode == MODE_FAILSAFE);
      nxt_s.was_fail = fail;
      clr_oc = '0;
      clr_ol = '0;
      rd = 32'h0000_0000;

      nxt_s.ov_m = i_supply_ov;
      nxt_s.ov_s = s_ff.ov_m;
      nxt_s.uv_m = i_supply_uv;
      nxt_s.uv_s = s_ff.uv_m;
      nxt_s.oc_m = i_overcurrent;
      nxt_s.oc_s = s_ff.oc_m;
      nxt_s.ol_m = i_undercurrent;
      nxt_s.ol_s = s_ff.ol_m;

      ov_act = s_ff.ov_s && !s_ff.ov_dis;
      uv_act = s_ff.uv_s && !s_ff.uv_dis;

      // Configuration is frozen outside Normal mode; flags clear anytime.
      if (wr) begin
         case (i_avs_address)
            REG_CFG_A: begin
               if (normal) begin
                  nxt_s.cfg[0] = wd[CFG_LO_LSB +: 3];
                  nxt_s.cfg[1] = wd[CFG_HI_LSB +: 3];
               end
            end
            REG_CFG_B: begin
               if (normal) begin
                  nxt_s.cfg[2] = wd[CFG_LO_LSB +: 3];
                  nxt_s.cfg[3] = wd[CFG_HI_LSB +: 3];
               end
            end
            REG_DUTY1: begin
               if (normal) begin
                  nxt_s.duty1 = wd;
               end
            end
            REG_DUTY2: begin
               if (normal) begin
                  nxt_s.duty2 = wd;
               end
            end
            REG_FREQ: begin
               if (normal) begin
                  nxt_s.freq = wd[1:0];
               end
            end
            REG_SUP_CTRL: begin
               if (normal) begin
                  nxt_s.ov_dis = wd[OV_DIS_BIT];
                  nxt_s.uv_dis = wd[UV_DIS_BIT];
                  nxt_s.rec = wd[REC_BIT];
               end
            end
            REG_OC_STAT: clr_oc = wd[N_OUT-1:0];
            REG_OL_STAT: clr_ol = wd[N_OUT-1:0];
            REG_SUP_STAT: begin
               nxt_s.ov_flag = s_ff.ov_flag && !wd[OV_FLAG_BIT];
               nxt_s.uv_flag = s_ff.uv_flag && !wd[UV_FLAG_BIT];
            end
            default: ;
         endcase
      end

      // Supply faults only touch their own flags.
      if (s_ff.ov_s) begin
         nxt_s.ov_flag = 1'b1;
      end
      if (s_ff.uv_s) begin
         nxt_s.uv_flag = 1'b1;
      end
      nxt_s.oc_flag = sticky(s_ff.oc_flag, clr_oc, oc_hit);
      nxt_s.ol_flag = sticky(s_ff.ol_flag, clr_ol, ol_hit);

      for (int i = 0; i < N_OUT; i++) begin
         if (oc_hit[i]) begin
            nxt_s.cfg[i] = CFG_OFF;
         end
      end
      if ((ov_act || uv_act) && !s_ff.rec) begin
         nxt_s.cfg = '0;
      end
      if (fail && !s_ff.was_fail) begin
         nxt_s.cfg = '0;
      end

      // A newly assigned PWM source drives the very next cycle.
      for (int i = 0; i < N_OUT; i++) begin
         nxt_s.out[i] = src_level(s_ff.cfg[i], i_timer1, i_timer2,
                                  pwm1_on, pwm2_on)
                        && !fail && !ov_act && !uv_act
                        && !oc_hit[i];
      end

      case (i_avs_address)
         REG_CFG_A: begin
            rd[CFG_LO_LSB +: 3] = s_ff.cfg[0];
            rd[CFG_HI_LSB +: 3] = s_ff.cfg[1];
         end
         REG_CFG_B: begin
            rd[CFG_LO_LSB +: 3] = s_ff.cfg[2];
            rd[CFG_HI_LSB +: 3] = s_ff.cfg[3];
         end
         REG_DUTY1: rd[7:0] = s_ff.duty1;
         REG_DUTY2: rd[7:0] = s_ff.duty2;
         REG_FREQ: rd[1:0] = s_ff.freq;
         REG_SUP_CTRL: begin
            rd[OV_DIS_BIT] = s_ff.ov_dis;
            rd[UV_DIS_BIT] = s_ff.uv_dis;
            rd[REC_BIT] = s_ff.rec;
         end
         REG_OC_STAT: rd[N_OUT-1:0] = s_ff.oc_flag;
         REG_OL_STAT: rd[N_OUT-1:0] = s_ff.ol_flag;
         REG_SUP_STAT: begin
            rd[OV_FLAG_BIT] = s_ff.ov_flag;
            rd[UV_FLAG_BIT] = s_ff.uv_flag;
            rd[OUT_STAT_LSB +: N_OUT] = s_ff.out;
         end
         default: rd = 32'h0000_0000;
      endcase
      if (req && s_ff.waitreq && i_avs_read) begin
         nxt_s.rdata = rd;
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
         s_ff <= '0;
         s_ff.waitreq <= 1'b1;
      end else begin
         s_ff <= nxt_s;
      end
   end

   assign o_avs_readdata = s_ff.rdata;
   assign o_avs_waitrequest = s_ff.waitreq;
   assign o_switch_output = s_ff.out;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (!i_resetn);

   property p_fail_off;
      fail |=> (o_switch_output == '0);
   endproperty
   a_fail_off: assert property (p_fail_off)
      else $error("Output on in Restart or Fail-Safe mode.");

   property p_ov_off;
      ov_act |=> (o_switch_output == '0);
   endproperty
   a_ov_off: assert property (p_ov_off)
      else $error("Output on during supply over-voltage.");

   property p_uv_off;
      uv_act |=> (o_switch_output == '0);
   endproperty
   a_uv_off: assert property (p_uv_off)
      else $error("Output on during supply under-voltage.");

   property p_norec_clear;
      ((ov_act || uv_act) && !s_ff.rec) |=> (s_ff.cfg == '0);
   endproperty
   a_norec_clear: assert property (p_norec_clear)
      else $error("Configuration kept without recovery.");

   property p_ov_flag;
      s_ff.ov_s ##1 s_ff.ov_s |-> s_ff.ov_flag;
   endproperty
   a_ov_flag: assert property (p_ov_flag)
      else $error("Over-voltage flag not set.");

   property p_oc_trip;
      oc_hit[0] |=> s_ff.oc_flag[0] && (s_ff.cfg[0] == CFG_OFF) && !o_switch_output[0];
   endproperty
   a_oc_trip: assert property (p_oc_trip)
      else $error("Over-current did not shut output.");

   property p_ol_stick;
      s_ff.ol_flag[0] && !clr_ol[0] |=> s_ff.ol_flag[0];
   endproperty
   a_ol_stick: assert property (p_ol_stick)
      else $error("Open-load flag dropped without clear.");

   property p_cfg_lock;
      (acc && i_avs_write && !normal) |=> $stable(s_ff.duty1) && $stable(s_ff.freq);
   endproperty
   a_cfg_lock: assert property (p_cfg_lock)
      else $error("Configuration changed outside Normal mode.");
endmodule

// file: bench/hs_load_model.sv
// Behavioural model of the four loads hanging on the switch outputs.
// Assumes the bench commands shorted or open loads; comparator levels are
// combinational from the switch drive, as the analog sense would be.
`timescale 1ns/1ps
module hs_load_model #(
   parameter int N = 4
) (
   // Switch drive seen at the pins
   input wire logic [N-1:0] i_drive,
   // Load faults commanded by the bench
   input wire logic [N-1:0] i_short,
   input wire logic [N-1:0] i_open,
   // Comparator levels, high = fault
   output logic [N-1:0] o_overcurrent,
   output logic [N-1:0] o_undercurrent
);
   // ----------------------------------------------------------------
   // Current sense
   // ----------------------------------------------------------------
   // A switch that is off carries no current, so the open-load comparator
   // reads high then; the controller must qualify it with its own drive.
   assign o_overcurrent = i_drive & i_short;
   assign o_undercurrent = ~i_drive | i_open;
endmodule

// file: bench/hs_switch_ctrl_test.sv
// Self-checking bench of the high-side switch controller.
// Assumes the load model on the switch pins and the Avalon-MM slave timing.
`timescale 1ns/1ps
module hs_switch_ctrl_test;
   import hs_switch_pkg::*;
   localparam int LIMIT = 90000;
   logic clk_sys = 1'b0;
   logic resetn;
   logic [5:0] address;
   logic read;
   logic write;
   logic [31:0] writedata;
   logic [3:0] byteenable;
   logic [31:0] readdata;
   logic waitrequest;
   mode_t mode;
   logic timer1;
   logic timer2;
   logic supply_ov;
   logic supply_uv;
   logic [3:0] overcurrent;
   logic [3:0] undercurrent;
   logic [3:0] switch_out;
   logic [3:0] short_load;
   logic [3:0] open_load;
   logic [31:0] rdata;
   int err_total = 0;
   int compares = 0;
   int cycles = 0;
   int hi0;
   int hi1;

   always #50 clk_sys = ~clk_sys;

   hs_switch_ctrl u_hs_switch_ctrl (
      .i_clk_sys(clk_sys), .i_resetn(resetn),
      .i_avs_address(address), .i_avs_read(read), .i_avs_write(write),
      .i_avs_writedata(writedata), .i_avs_byteenable(byteenable),
      .o_avs_readdata(readdata), .o_avs_waitrequest(waitrequest),
      .i_mode(mode), .i_timer1(timer1), .i_timer2(timer2),
      .i_supply_ov(supply_ov), .i_supply_uv(supply_uv),
      .i_overcurrent(overcurrent), .i_undercurrent(undercurrent),
      .o_switch_output(switch_out)
   );

   hs_load_model u_hs_load_model (
      .i_drive(switch_out), .i_short(short_load), .i_open(open_load),
      .o_overcurrent(overcurrent), .o_undercurrent(undercurrent)
   );

   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   task final_report;
      $display("compares=%0d err_total=%0d", compares, err_total);
      if (err_total == 0 && compares > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   task chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
         err_total++;
      end
   endtask

   // The request is held until the edge that samples waitrequest low.
   task bus(input logic wr, input logic [5:0] a, input logic [7:0] d,
            input logic [3:0] be);
      @(posedge clk_sys);
      address <= a;
      writedata <= {24'h0, d};
      byteenable <= be;
      write <= wr;
      read <= ~wr;
      do begin
         @(posedge clk_sys);
      end while (waitrequest !== 1'b0);
      rdata = readdata;
      read <= 1'b0;
      write <= 1'b0;
      // Waitrequest stands low for one cycle only, then the slave waits again.
      @(posedge clk_sys);
      chk({31'h0, waitrequest}, 32'h1);
   endtask

   task wr(input logic [5:0] a, input logic [7:0] d);
      bus(1'b1, a, d, 4'h1);
   endtask

   task rd(input logic [5:0] a, input logic [7:0] exp);
      bus(1'b0, a, 8'h00, 4'hf);
      chk(rdata, {24'h0, exp});
   endtask

   task outs(input logic [3:0] exp);
      chk({28'h0, switch_out}, {28'h0, exp});
   endtask

   task cyc(input int n);
      repeat (n) @(posedge clk_sys);
   endtask

   // ----------------------------------------------------------------
   // Hang guard
   // ----------------------------------------------------------------
   always @(posedge clk_sys) begin
      cycles <= cycles + 1;
      if (cycles == LIMIT) begin
         err_total++;
         final_report();
      end
   end

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      resetn = 1'b0;
      address = 6'h00;
      read = 1'b0;
      write = 1'b0;
      writedata = 32'h0;
      byteenable = 4'h0;
      mode = MODE_NORMAL;
      timer1 = 1'b1;
      timer2 = 1'b0;
      supply_ov = 1'b0;
      supply_uv = 1'b0;
      short_load = 4'h0;
      open_load = 4'h0;
      repeat (6) @(posedge clk_sys);
      resetn <= 1'b1;
      outs(4'h0);
      rd(REG_CFG_A, 8'h00);
      rd(REG_SUP_CTRL, 8'h00);
      rd(REG_SUP_STAT, 8'h00);
      rd(6'h3c, 8'h00);
      // Output 1 on, output 2 from timer 1, output 3 from timer 2.
      wr(REG_CFG_A, 8'h21);
      wr(REG_CFG_B, 8'h03);
      cyc(2);
      outs(4'b0011);
      timer1 <= 1'b0;
      timer2 <= 1'b1;
      cyc(2);
      outs(4'b0101);
      rd(REG_SUP_STAT, 8'h50);
      bus(1'b1, REG_CFG_A, 8'h00, 4'h0);
      wr(6'h3c, 8'hff);
      rd(REG_CFG_A, 8'h21);
      // Frozen configuration and live over-current shutdown in Stop.
      mode <= MODE_STOP;
      wr(REG_CFG_A, 8'h00);
      rd(REG_CFG_A, 8'h21);
      short_load <= 4'h1;
      cyc(150);
      outs(4'b0101);
      cyc(20);
      outs(4'b0100);
      rd(REG_OC_STAT, 8'h01);
      rd(REG_CFG_A, 8'h20);
      short_load <= 4'h0;
      wr(REG_OC_STAT, 8'h01);
      rd(REG_OC_STAT, 8'h00);
      mode <= MODE_NORMAL;
      wr(REG_CFG_A, 8'h21);
      cyc(2);
      outs(4'b0101);
      // Open load on output 3 needs the full filter time; output stays on.
      open_load <= 4'h4;
      cyc(600);
      rd(REG_OL_STAT, 8'h00);
      cyc(60);
      rd(REG_OL_STAT, 8'h04);
      outs(4'b0101);
      open_load <= 4'h0;
      cyc(10);
      rd(REG_OL_STAT, 8'h04);
      wr(REG_OL_STAT, 8'h04);
      rd(REG_OL_STAT, 8'h00);
      // Over-voltage with recovery, then with shutdown disabled.
      wr(REG_SUP_CTRL, 8'h04);
      supply_ov <= 1'b1;
      cyc(5);
      outs(4'b0000);
      rd(REG_SUP_STAT, 8'h01);
      rd(REG_OC_STAT, 8'h00);
      rd(REG_OL_STAT, 8'h00);
      supply_ov <= 1'b0;
      cyc(5);
      outs(4'b0101);
      wr(REG_SUP_STAT, 8'h01);
      rd(REG_SUP_STAT, 8'h50);
      wr(REG_SUP_CTRL, 8'h05);
      supply_ov <= 1'b1;
      cyc(5);
      outs(4'b0101);
      supply_ov <= 1'b0;
      cyc(5);
      wr(REG_SUP_STAT, 8'h01);
      // Under-voltage without recovery clears the configuration.
      wr(REG_SUP_CTRL, 8'h00);
      supply_uv <= 1'b1;
      cyc(5);
      outs(4'b0000);
      supply_uv <= 1'b0;
      cyc(5);
      outs(4'b0000);
      rd(REG_CFG_A, 8'h00);
      rd(REG_CFG_B, 8'h00);
      rd(REG_SUP_STAT, 8'h02);
      wr(REG_SUP_STAT, 8'h02);
      // Restart forces the outputs off; software re-enables afterwards.
      wr(REG_CFG_A, 8'h01);
      cyc(2);
      outs(4'b0001);
      mode <= MODE_RESTART;
      cyc(3);
      outs(4'b0000);
      rd(REG_CFG_A, 8'h00);
      mode <= MODE_NORMAL;
      cyc(2);
      wr(REG_CFG_A, 8'h01);
      cyc(2);
      outs(4'b0001);
      // Generator 1 at 400 Hz, duty 64; generator 2 at duty zero.
      wr(REG_DUTY1, 8'h40);
      wr(REG_DUTY2, 8'h00);
      wr(REG_FREQ, 8'h01);
      rd(REG_DUTY1, 8'h40);
      rd(REG_FREQ, 8'h01);
      wr(REG_CFG_B, 8'h54);
      cyc(4);
      hi0 = 0;
      hi1 = 0;
      // Any window of one whole period holds exactly the duty share.
      for (int k = 0; k < PWM_STEPS * PWM_STEP_HI; k++) begin
         @(posedge clk_sys);
         hi0 += int'(switch_out[2]);
         hi1 += int'(switch_out[3]);
      end
      chk(hi0, 64 * PWM_STEP_HI);
      chk(hi1, 0);
      rd(REG_CFG_B, 8'h54);
      // Both generators at 200 Hz; generator 2 at duty 32.
      wr(REG_FREQ, 8'h00);
      wr(REG_DUTY2, 8'h20);
      cyc(4);
      hi0 = 0;
      hi1 = 0;
      for (int k = 0; k < PWM_STEPS * PWM_STEP_LO; k++) begin
         @(posedge clk_sys);
         hi0 += int'(switch_out[2]);
         hi1 += int'(switch_out[3]);
      end
      chk(hi0, 64 * PWM_STEP_LO);
      chk(hi1, 32 * PWM_STEP_LO);
      // Sleep keeps the settings; Fail-Safe then forces the outputs off.
      mode <= MODE_SLEEP;
      wr(REG_DUTY1, 8'h80);
      wr(REG_FREQ, 8'h03);
      rd(REG_DUTY1, 8'h40);
      rd(REG_FREQ, 8'h00);
      rd(REG_CFG_B, 8'h54);
      mode <= MODE_FAILSAFE;
      cyc(3);
      outs(4'b0000);
      rd(REG_CFG_B, 8'h00);
      final_report();
   end
endmodule
